/* File: design/gdct_ctrl.sv */
// Controller end: software registers over Avalon-MM, command timing, strobes.
// Assumes the memory end on the link interface and the same sys_clk.
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "gdct_defines.svh"
// Operation
// - Seven cycles after mode load before anything
// - Nine cycles after mode load before read
// - Refresh 8K per 32ms, every 3.9us
// - At most four activates per rolling window
// - Window in cycles, time over period, up
// - Auto precharge waits for row active minimum
// - DLL reset, then 5K cycles before reads
// - Write latency 1..6, data that late
// - Latency 1 or 3: buffers always on
// - Latency 4 or 6: buffers only writing
// - Write recovery cycles rounded up into mode
// - Controller drives final write strobe rise high
// - Memory drives final read strobe rise
// - Read preamble low before first rising edge
// - Write strobe valid by write command cycle
// - Clock enable high during refresh, else low; the controller also holds it high for commands, open rows, strobes and reads
// - Read strobe n covers byte lane n
module gdct_ctrl
#(
  parameter int DLL_CYCLES = `GDCT_DLL_CYCLES,
  parameter int READ_LAT   = `GDCT_READ_LAT
)
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output gdct_pkg::gdct_cmd_t issued_cmd,
  gdct_link_if.ctrl        lnk
);
  import gdct_pkg::*;

  // Times to cycles: least times round up, the refresh interval rounds down
  localparam int FAW_CYC  = (`GDCT_FAW_NS * 1000 + `GDCT_CLK_PS - 1) / `GDCT_CLK_PS;
  localparam int RRD_CYC  = (`GDCT_RRD_NS * 1000 + `GDCT_CLK_PS - 1) / `GDCT_CLK_PS;
  localparam int RAS_CYC  = (`GDCT_RAS_NS * 1000 + `GDCT_CLK_PS - 1) / `GDCT_CLK_PS;
  localparam int WR_CYC   = (`GDCT_WR_NS * 1000 + `GDCT_CLK_PS - 1) / `GDCT_CLK_PS;
  localparam int RFC_CYC  = (`GDCT_RFC_NS * 1000 + `GDCT_CLK_PS - 1) / `GDCT_CLK_PS;
  localparam int REFI_CYC = (`GDCT_REFI_NS * 1000) / `GDCT_CLK_PS;

  if (DLL_CYCLES < 1 || DLL_CYCLES > 65535 || READ_LAT < 3 || READ_LAT > 15
      || WR_CYC > 31)
  begin : g_chk
    $error("gdct_ctrl: parameter out of range");
  end

  // Bank number to one-hot, used for activate, precharge and close
  function automatic logic [7:0] bank_hot(input logic [2:0] b);
    bank_hot = 8'h01 << b;
  endfunction

  logic        pend_r, pend_nxt, ap_r, ap_nxt;
  gdct_cmd_t   op_r, op_nxt, cmd_o_r, cmd_o_nxt, last_r, last_nxt;
  logic [2:0]  bank_r, bank_nxt, bank_o_r, bank_o_nxt, wl_r, wl_nxt;
  logic        ap_o_r, ap_o_nxt, cke_r, cke_nxt, rvalid_r, rvalid_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt, lwdata_r, lwdata_nxt;
  logic [31:0] rdo_r, rdo_nxt;
  logic        rd_ack_r, rd_ack_nxt, ref_pend_r, ref_pend_nxt;
  gdct_cnt_t   gap_r, gap_nxt, mtr_r, mtr_nxt, refi_r, refi_nxt, rfc_r, rfc_nxt;
  gdct_cnt_t   dll_r, dll_nxt, rrd_r, rrd_nxt, rdw_r, rdw_nxt;
  gdct_cnt_t   faw_r [`GDCT_FAW_ACTS];
  gdct_cnt_t   faw_nxt [`GDCT_FAW_ACTS];
  gdct_strb_t  ws_r, ws_nxt;
  logic [2:0]  wcnt_r, wcnt_nxt;
  logic        ws_lvl_r, ws_lvl_nxt, ws_oe_r, ws_oe_nxt;
  logic [7:0]  open_w, ready_w, ras_ok_w, act_w, pre_w, apc_w;
  logic        faw_free, sw_ok, go_ref, go_sw, wr_take, cmd_stall;
  gdct_cmd_t   go_cmd;

  // Per-bank row timers: open flag, row active minimum, reopen hold
  for (genvar b = 0; b < `GDCT_NUM_BANKS; b++)
  begin : g_bank
    logic      open_r, open_nxt;
    gdct_cnt_t ras_r, ras_nxt, hold_r, hold_nxt;
    assign open_w[b]   = open_r;
    assign ras_ok_w[b] = (ras_r == '0);
    assign ready_w[b]  = !open_r && (hold_r == '0);

    always_comb
    begin
      open_nxt = open_r;
      ras_nxt  = (ras_r != '0) ? ras_r - 16'h0001 : ras_r;
      hold_nxt = (hold_r != '0) ? hold_r - 16'h0001 : hold_r;
      if (act_w[b])
      begin
        open_nxt = 1'b1;
        ras_nxt  = 16'(RAS_CYC);
      end
      else if (pre_w[b])
        open_nxt = 1'b0;
      else if (apc_w[b])
      begin
        open_nxt = 1'b0;
        hold_nxt = ras_r + 16'(WR_CYC);
      end
    end

    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
      begin
        open_r <= 1'b0;
        ras_r  <= '0;
        hold_r <= '0;
      end
      else
      begin
        open_r <= open_nxt;
        ras_r  <= ras_nxt;
        hold_r <= hold_nxt;
      end
    end
  end

  // Bus answers: reads wait one cycle, a command write waits while one pends
  assign cmd_stall       = avs_write && (avs_address == `GDCT_REG_CMD) && pend_r;
  assign avs_waitrequest = (avs_read && !rd_ack_r) || cmd_stall;
  assign wr_take         = avs_write && !cmd_stall;

  // Spacing checks ahead of any issue
  always_comb
  begin
    faw_free = 1'b0;
    for (int i = 0; i < `GDCT_FAW_ACTS; i++)
      faw_free = faw_free || (faw_r[i] == '0);
    case (op_r)
      GDCT_RD:  sw_ok = (mtr_r == '0) && (dll_r == '0) && open_w[bank_r]
                        && (ws_r == STRB_OFF) && (rdw_r == '0);
      GDCT_WR:  sw_ok = open_w[bank_r] && (ws_r == STRB_OFF) && (rdw_r == '0);
      GDCT_ACT: sw_ok = ready_w[bank_r] && faw_free && (rrd_r == '0);
      GDCT_PRE: sw_ok = ras_ok_w[bank_r];
      GDCT_REF: sw_ok = !(|open_w);
      GDCT_MRS: sw_ok = (ws_r == STRB_OFF) && (rdw_r == '0);
      default:  sw_ok = 1'b1;
    endcase
    go_ref = ref_pend_r && !(|open_w) && (gap_r == '0) && (rfc_r == '0);
    go_sw  = pend_r && sw_ok && !go_ref && (gap_r == '0) && (rfc_r == '0);
    go_cmd = go_ref ? GDCT_REF : (go_sw ? op_r : GDCT_NOP);
    act_w  = (go_cmd == GDCT_ACT) ? bank_hot(bank_r) : 8'h00;
    pre_w  = (go_cmd == GDCT_PRE) ? bank_hot(bank_r) : 8'h00;
    apc_w  = ((go_cmd == GDCT_RD) || (go_cmd == GDCT_WR)) && ap_r ? bank_hot(bank_r) : 8'h00;
  end

  // Registers, counters, issue and strobe sequencing
  always_comb
  begin
    pend_nxt = pend_r && !go_sw;
    op_nxt   = op_r;
    bank_nxt = bank_r;
    ap_nxt   = ap_r;
    wl_nxt   = wl_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = rvalid_r && !(rd_ack_r && avs_address == `GDCT_REG_RDATA);
    gap_nxt  = (gap_r != '0) ? gap_r - 16'h0001 : gap_r;
    mtr_nxt  = (mtr_r != '0) ? mtr_r - 16'h0001 : mtr_r;
    rfc_nxt  = (rfc_r != '0) ? rfc_r - 16'h0001 : rfc_r;
    dll_nxt  = (dll_r != '0) ? dll_r - 16'h0001 : dll_r;
    rrd_nxt  = (rrd_r != '0) ? rrd_r - 16'h0001 : rrd_r;
    rdw_nxt  = (rdw_r != '0) ? rdw_r - 16'h0001 : rdw_r;
    // Reload one short: a full REFI_CYC period, never one cycle more
    refi_nxt = (refi_r != '0) ? refi_r - 16'h0001 : 16'(REFI_CYC - 1);
    // Expiry sets the request; an expiry in the issue cycle is kept
    ref_pend_nxt = (ref_pend_r && !go_ref) || (refi_r == '0);
    for (int i = 0; i < `GDCT_FAW_ACTS; i++)
      faw_nxt[i] = (faw_r[i] != '0) ? faw_r[i] - 16'h0001 : faw_r[i];
    // Software writes with byte enables
    if (wr_take)
    begin
      case (avs_address)
        `GDCT_REG_CMD:
          if (avs_byteenable[0])
          begin
            pend_nxt = 1'b1;
            op_nxt   = gdct_cmd_t'(avs_writedata[2:0]);
            bank_nxt = avs_writedata[`GDCT_CMD_BANK_LSB +: 3];
            ap_nxt   = avs_writedata[`GDCT_CMD_AP_BIT];
          end
        `GDCT_REG_MODE:
          if (avs_byteenable[0] && avs_writedata[2:0] >= 3'(`GDCT_WL_MIN)
              && avs_writedata[2:0] <= 3'(`GDCT_WL_MAX))
            wl_nxt = avs_writedata[2:0];
        `GDCT_REG_WDATA:
          for (int l = 0; l < 4; l++)
            if (avs_byteenable[l])
              wdata_nxt[8*l +: 8] = avs_writedata[8*l +: 8];
        default: ;
      endcase
    end
    // Loading counters on issue
    case (go_cmd)
      GDCT_MRS:
      begin
        gap_nxt = 16'(`GDCT_MODE_LOAD_GAP);
        mtr_nxt = 16'(`GDCT_MODE_TO_READ);
      end
      GDCT_ACT:
      begin
        rrd_nxt = 16'(RRD_CYC);
        for (int i = `GDCT_FAW_ACTS - 1; i >= 0; i--)
          if (faw_r[i] == '0)
            faw_nxt[i] = 16'(FAW_CYC);
      end
      GDCT_REF:  rfc_nxt = 16'(RFC_CYC);
      GDCT_DLLR: dll_nxt = 16'(DLL_CYCLES);
      GDCT_RD:   rdw_nxt = 16'(READ_LAT + 3);
      default: ;
    endcase
    // Lowest free window slot only, so one activate uses one slot
    if (go_cmd == GDCT_ACT)
      for (int i = 0; i < `GDCT_FAW_ACTS; i++)
        if (faw_r[i] == '0)
          for (int j = i + 1; j < `GDCT_FAW_ACTS; j++)
            if (faw_r[j] == '0)
              faw_nxt[j] = '0;
    cmd_o_nxt  = go_cmd;
    bank_o_nxt = bank_r;
    ap_o_nxt   = ap_r;
    last_nxt   = (go_cmd != GDCT_NOP) ? go_cmd : last_r;
    // Enable held through refresh and activity, low in standby
    cke_nxt = (go_cmd != GDCT_NOP) || (rfc_nxt != '0) || (|open_w)
              || (ws_r != STRB_OFF) || (rdw_r != '0);
    // Write strobe: valid low from the command, high with data, postamble, final rise
    wcnt_nxt   = (wcnt_r != 3'h0) ? wcnt_r - 3'h1 : wcnt_r;
    lwdata_nxt = lwdata_r;
    case (ws_r)
      STRB_OFF:
        if (go_cmd == GDCT_WR)
        begin
          ws_nxt   = STRB_PRE;
          wcnt_nxt = wl_r;
        end
        else
          ws_nxt = STRB_OFF;
      STRB_PRE:
        if (wcnt_r == 3'h1)
        begin
          ws_nxt     = STRB_DATA;
          lwdata_nxt = wdata_r;
        end
        else
          ws_nxt = STRB_PRE;
      STRB_DATA:  ws_nxt = STRB_POST;
      STRB_POST:  ws_nxt = STRB_FINAL;
      STRB_FINAL: ws_nxt = STRB_OFF;
      default:    ws_nxt = STRB_OFF;
    endcase
    ws_lvl_nxt = (ws_nxt == STRB_DATA) || (ws_nxt == STRB_FINAL);
    ws_oe_nxt  = (ws_nxt != STRB_OFF);
    // Each lane taken on its own strobe
    for (int l = 0; l < 4; l++)
      if (lnk.read_strobe_oe[l] && lnk.read_strobe_o[l] && lnk.rdata_oe)
      begin
        rdata_nxt[8*l +: 8] = lnk.rdata[8*l +: 8];
        rvalid_nxt          = 1'b1;
      end
    // Registered read answer
    rd_ack_nxt = avs_read && !rd_ack_r;
    rdo_nxt    = rdo_r;
    if (avs_read && !rd_ack_r)
      case (avs_address)
        `GDCT_REG_CMD:    rdo_nxt = {25'h0, ap_r, bank_r, op_r};
        `GDCT_REG_MODE:   rdo_nxt = {24'h0, 5'(WR_CYC), wl_r};
        `GDCT_REG_WDATA:  rdo_nxt = wdata_r;
        `GDCT_REG_RDATA:  rdo_nxt = rdata_r;
        `GDCT_REG_STATUS: rdo_nxt = {26'h0, (ws_r != STRB_OFF), ref_pend_r, cke_r,
                                     rvalid_r, (dll_r == '0), pend_r};
        default:          rdo_nxt = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      pend_r <= 1'b0;   op_r <= GDCT_NOP;   bank_r <= '0;   ap_r <= 1'b0;
      wl_r <= `GDCT_WL_RESET;   wdata_r <= '0;   rdata_r <= '0;   rvalid_r <= 1'b0;
      gap_r <= '0;   mtr_r <= '0;   rfc_r <= '0;   rrd_r <= '0;   rdw_r <= '0;
      dll_r <= 16'(DLL_CYCLES);   refi_r <= 16'(REFI_CYC - 1);   ref_pend_r <= 1'b0;
      for (int i = 0; i < `GDCT_FAW_ACTS; i++)
        faw_r[i] <= '0;
      cmd_o_r <= GDCT_NOP;   bank_o_r <= '0;   ap_o_r <= 1'b0;   last_r <= GDCT_NOP;
      cke_r <= 1'b0;   ws_r <= STRB_OFF;   wcnt_r <= '0;   lwdata_r <= '0;
      ws_lvl_r <= 1'b0;   ws_oe_r <= 1'b0;   rd_ack_r <= 1'b0;   rdo_r <= '0;
    end
    else
    begin
      pend_r <= pend_nxt;   op_r <= op_nxt;   bank_r <= bank_nxt;   ap_r <= ap_nxt;
      wl_r <= wl_nxt;   wdata_r <= wdata_nxt;   rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;   gap_r <= gap_nxt;   mtr_r <= mtr_nxt;   rfc_r <= rfc_nxt;
      rrd_r <= rrd_nxt;   rdw_r <= rdw_nxt;   dll_r <= dll_nxt;   refi_r <= refi_nxt;
      ref_pend_r <= ref_pend_nxt;   faw_r <= faw_nxt;
      cmd_o_r <= cmd_o_nxt;   bank_o_r <= bank_o_nxt;   ap_o_r <= ap_o_nxt;
      last_r <= last_nxt;   cke_r <= cke_nxt;   ws_r <= ws_nxt;   wcnt_r <= wcnt_nxt;
      lwdata_r <= lwdata_nxt;   ws_lvl_r <= ws_lvl_nxt;   ws_oe_r <= ws_oe_nxt;
      rd_ack_r <= rd_ack_nxt;   rdo_r <= rdo_nxt;
    end
  end

  // Link drive from registers
  assign lnk.cke             = cke_r;
  assign lnk.cmd             = cmd_o_r;
  assign lnk.bank            = bank_o_r;
  assign lnk.ap              = ap_o_r;
  assign lnk.mode            = {5'(WR_CYC), wl_r};
  assign lnk.wdata           = lwdata_r;
  assign lnk.wdata_oe        = (ws_r == STRB_DATA);
  assign lnk.write_strobe_o  = ws_lvl_r;
  assign lnk.write_strobe_oe = ws_oe_r;
  assign avs_readdata        = rdo_r;
  assign issued_cmd          = last_r;

endmodule

/* File: design/gdct_defines.svh */
// Named constants of the graphics DRAM command-timing link.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef GDCT_DEFINES_SVH
`define GDCT_DEFINES_SVH

// Clock period and documented spacings
`define GDCT_CLK_PS        10000
`define GDCT_MODE_LOAD_GAP 7
`define GDCT_MODE_TO_READ  9
`define GDCT_REFI_NS       3900
`define GDCT_REF_PER_WIN   8192
`define GDCT_REF_WIN_MS    32
`define GDCT_DLL_CYCLES    5000
`define GDCT_FAW_ACTS      4
`define GDCT_WL_MIN        1
`define GDCT_WL_MAX        6

// Core times in ns, plain defaults; read latency in cycles and the bank count
`define GDCT_FAW_NS        40
`define GDCT_RRD_NS        10
`define GDCT_RAS_NS        30
`define GDCT_WR_NS         12
`define GDCT_RFC_NS        50
`define GDCT_READ_LAT      4
`define GDCT_NUM_BANKS     8

// Register word indices on the software bus
`define GDCT_REG_CMD       3'h0
`define GDCT_REG_MODE      3'h1
`define GDCT_REG_WDATA     3'h2
`define GDCT_REG_RDATA     3'h3
`define GDCT_REG_STATUS    3'h4

// Field positions and the write latency reset value
`define GDCT_CMD_BANK_LSB  3
`define GDCT_CMD_AP_BIT    6
`define GDCT_MODE_WRA_LSB  3
`define GDCT_WL_RESET      3'h1
`define GDCT_ST_PEND       0
`define GDCT_ST_DLL        1
`define GDCT_ST_RVALID     2
`define GDCT_ST_CKE        3
`define GDCT_ST_REF        4
`define GDCT_ST_WBUSY      5

`endif

/* File: design/gdct_link_if.sv */
// Link between controller and memory: command, mode, data and strobes.
// Assumes one shared clock; each direction has its own wires, data and strobes each with its own enable.
`timescale 1ns/100ps
interface gdct_link_if;
  import gdct_pkg::*;

  logic            cke;
  gdct_cmd_t       cmd;
  logic [2:0]      bank;
  logic            ap;
  logic [7:0]      mode;
  logic [31:0]     wdata;
  logic            wdata_oe;
  logic            write_strobe_o;
  logic            write_strobe_oe;
  logic [31:0]     rdata;
  logic            rdata_oe;
  logic [3:0]      read_strobe_o;
  logic [3:0]      read_strobe_oe;

  modport ctrl (
    output cke, cmd, bank, ap, mode, wdata, wdata_oe, write_strobe_o, write_strobe_oe,
    input  rdata, rdata_oe, read_strobe_o, read_strobe_oe
  );

  modport mem (
    input  cke, cmd, bank, ap, mode, wdata, wdata_oe, write_strobe_o, write_strobe_oe,
    output rdata, rdata_oe, read_strobe_o, read_strobe_oe
  );

endinterface

/* File: design/gdct_mem.sv */
// Memory end: eight banks, mode register, write capture, read strobes.
// Assumes the controller keeps all command spacing; commands need cke high.
`timescale 1ns/100ps
`include "gdct_defines.svh"
module gdct_mem
#(
  parameter int DLL_CYCLES = `GDCT_DLL_CYCLES,
  parameter int READ_LAT   = `GDCT_READ_LAT
)
(
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  gdct_link_if.mem          lnk,
  output gdct_pkg::gdct_cnt_t dll_wait,
  output logic              dll_locked,
  output logic              in_buf_en,
  output logic [7:0]        bank_open,
  output logic [2:0]        wl_cur
);
  import gdct_pkg::*;

  localparam int RAS_CYC = (`GDCT_RAS_NS * 1000 + `GDCT_CLK_PS - 1) / `GDCT_CLK_PS;

  // Refuse figures the counters cannot hold
  if (DLL_CYCLES < 1 || DLL_CYCLES > 65535 || READ_LAT < 3 || READ_LAT > 15)
  begin : g_chk
    $error("gdct_mem: parameter out of range");
  end

  logic [2:0]  wl_r, wl_nxt;
  logic [4:0]  wra_r, wra_nxt;
  gdct_cnt_t   dll_r, dll_nxt;
  logic [2:0]  wcnt_r, wcnt_nxt, wbank_r, wbank_nxt;
  logic [3:0]  rcnt_r, rcnt_nxt;
  logic [2:0]  rbank_r, rbank_nxt;
  gdct_strb_t  rs_r, rs_nxt;
  logic        rs_lvl_r, rs_lvl_nxt, rs_oe_r, rs_oe_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] mem_r [8];
  logic [31:0] mem_nxt [8];
  logic [7:0]  open_w, act_w, pre_w, ap_w;
  logic        buf_on;
  gdct_cmd_t   cmd_v;

  // Commands only count while clock enable is high
  assign cmd_v = lnk.cke ? lnk.cmd : GDCT_NOP;

  // Write latency 1 or 3 keeps buffers on; latencies 2, 4, 5 and 6 open them per write
  assign buf_on = (wl_r == 3'h1) || (wl_r == 3'h3) || (wcnt_r != 3'h0);

  // Per-bank row state with auto-precharge hold-off
  for (genvar b = 0; b < `GDCT_NUM_BANKS; b++)
  begin : g_bank
    logic      open_r, open_nxt, apd_r, apd_nxt;
    gdct_cnt_t ras_r, ras_nxt;
    assign act_w[b] = (cmd_v == GDCT_ACT) && (lnk.bank == 3'(b));
    assign pre_w[b] = (cmd_v == GDCT_PRE) && (lnk.bank == 3'(b));
    assign ap_w[b]  = ((cmd_v == GDCT_RD) || (cmd_v == GDCT_WR)) && lnk.ap
                      && (lnk.bank == 3'(b));
    assign open_w[b] = open_r;

    always_comb
    begin
      open_nxt = open_r;
      apd_nxt  = apd_r || ap_w[b];
      ras_nxt  = (ras_r != '0) ? ras_r - 16'h0001 : ras_r;
      if (act_w[b])
      begin
        open_nxt = 1'b1;
        ras_nxt  = 16'(RAS_CYC);
      end
      else if (pre_w[b])
        open_nxt = 1'b0;
      else if (apd_r && (ras_r == '0))
      begin
        open_nxt = 1'b0;
        apd_nxt  = 1'b0;
      end
    end

    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
      begin
        open_r <= 1'b0;
        apd_r  <= 1'b0;
        ras_r  <= '0;
      end
      else
      begin
        open_r <= open_nxt;
        apd_r  <= apd_nxt;
        ras_r  <= ras_nxt;
      end
    end
  end

  // Mode, DLL, write capture and read sequencing
  always_comb
  begin
    wl_nxt     = wl_r;
    wra_nxt    = wra_r;
    dll_nxt    = (dll_r != '0) ? dll_r - 16'h0001 : dll_r;
    wcnt_nxt   = (wcnt_r != 3'h0) ? wcnt_r - 3'h1 : wcnt_r;
    wbank_nxt  = wbank_r;
    rcnt_nxt   = (rcnt_r != 4'h0) ? rcnt_r - 4'h1 : rcnt_r;
    rbank_nxt  = rbank_r;
    rs_nxt     = rs_r;
    rdata_nxt  = rdata_r;
    mem_nxt    = mem_r;
    case (cmd_v)
      GDCT_MRS:
      begin
        if (lnk.mode[2:0] >= 3'(`GDCT_WL_MIN) && lnk.mode[2:0] <= 3'(`GDCT_WL_MAX))
          wl_nxt = lnk.mode[2:0];
        wra_nxt = lnk.mode[7:`GDCT_MODE_WRA_LSB];
      end
      GDCT_WR:
      begin
        wcnt_nxt  = wl_r;
        wbank_nxt = lnk.bank;
      end
      GDCT_RD:
      begin
        rcnt_nxt  = 4'(READ_LAT);
        rbank_nxt = lnk.bank;
      end
      GDCT_DLLR: dll_nxt = 16'(DLL_CYCLES);
      default: ;
    endcase
    // Data taken exactly write-latency cycles after the command
    if (wcnt_r == 3'h1 && buf_on)
      mem_nxt[wbank_r] = lnk.wdata;
    // Low preamble, data high, low postamble, own final rising drive
    case (rs_r)
      STRB_OFF:   if (rcnt_r == 4'h3) rs_nxt = STRB_PRE;
      STRB_PRE:
      begin
        rs_nxt    = STRB_DATA;
        rdata_nxt = mem_r[rbank_r];
      end
      STRB_DATA:  rs_nxt = STRB_POST;
      STRB_POST:  rs_nxt = STRB_FINAL;
      STRB_FINAL: rs_nxt = STRB_OFF;
      default:    rs_nxt = STRB_OFF;
    endcase
    rs_lvl_nxt = (rs_nxt == STRB_DATA) || (rs_nxt == STRB_FINAL);
    rs_oe_nxt  = (rs_nxt != STRB_OFF);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wl_r     <= `GDCT_WL_RESET;
      wra_r    <= '0;
      dll_r    <= 16'(DLL_CYCLES);
      wcnt_r   <= '0;
      wbank_r  <= '0;
      rcnt_r   <= '0;
      rbank_r  <= '0;
      rs_r     <= STRB_OFF;
      rs_lvl_r <= 1'b0;
      rs_oe_r  <= 1'b0;
      rdata_r  <= '0;
      for (int i = 0; i < `GDCT_NUM_BANKS; i++)
        mem_r[i] <= '0;
    end
    else
    begin
      wl_r     <= wl_nxt;
      wra_r    <= wra_nxt;
      dll_r    <= dll_nxt;
      wcnt_r   <= wcnt_nxt;
      wbank_r  <= wbank_nxt;
      rcnt_r   <= rcnt_nxt;
      rbank_r  <= rbank_nxt;
      rs_r     <= rs_nxt;
      rs_lvl_r <= rs_lvl_nxt;
      rs_oe_r  <= rs_oe_nxt;
      rdata_r  <= rdata_nxt;
      mem_r    <= mem_nxt;
    end
  end

  // One strobe per byte lane, all four move together
  assign lnk.read_strobe_o  = {4{rs_lvl_r}};
  assign lnk.read_strobe_oe = {4{rs_oe_r}};
  assign lnk.rdata          = rdata_r;
  assign lnk.rdata_oe       = (rs_r == STRB_DATA);
  assign dll_wait           = dll_r;
  assign dll_locked         = (dll_r == '0);
  assign in_buf_en          = buf_on;
  assign bank_open          = open_w;
  assign wl_cur             = wl_r;

endmodule

/* File: design/gdct_pkg.sv */
// Types shared by both ends of the graphics DRAM command-timing link.
// Assumes nothing beyond a SystemVerilog compiler.
package gdct_pkg;

  // Commands on the link
  typedef enum logic [2:0] {
    GDCT_NOP,
    GDCT_MRS,
    GDCT_ACT,
    GDCT_RD,
    GDCT_WR,
    GDCT_PRE,
    GDCT_REF,
    GDCT_DLLR
  } gdct_cmd_t;

  // Strobe sequencing, shared by write and read strobes
  typedef enum logic [2:0] {
    STRB_OFF,
    STRB_PRE,
    STRB_DATA,
    STRB_POST,
    STRB_FINAL
  } gdct_strb_t;

  typedef logic [15:0] gdct_cnt_t;

endpackage

/* File: tb/gdct_link_checker.sv */
// Concurrent checks on the controller-to-memory link.
// Assumes the link signals as plain inputs and the default READ_LAT of 4.
`timescale 1ns/100ps
module gdct_link_checker
(
  input wire logic                sys_clk,
  input wire logic                rst_n,
  input wire logic                cke,
  input wire gdct_pkg::gdct_cmd_t cmd,
  input wire logic [7:0]          mode,
  input wire logic                wdata_oe,
  input wire logic                write_strobe_o,
  input wire logic                write_strobe_oe,
  input wire logic                rdata_oe,
  input wire logic [3:0]          read_strobe_o,
  input wire logic [3:0]          read_strobe_oe
);
  import gdct_pkg::*;
  // One clock domain, so one clocking and one reset for all
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Mode load spacing and recovery payload
  chk_mrs_gap: assert property (cmd == GDCT_MRS |=> cmd == GDCT_NOP [*6])
    else $error("command inside mode load gap");
  chk_mrs_read: assert property (cmd == GDCT_MRS |=> cmd != GDCT_RD [*8])
    else $error("read too soon after mode load");
  chk_mrs_wra: assert property (cmd == GDCT_MRS |-> mode[7:3] == 5'h2)
    else $error("write recovery count wrong");
  // Refresh keeps cke up and the link quiet
  chk_ref_cke: assert property (cmd == GDCT_REF |-> cke [*5])
    else $error("cke low in refresh period");
  chk_ref_quiet: assert property (cmd == GDCT_REF |=> cmd == GDCT_NOP [*4])
    else $error("command inside refresh period");
  // Write strobe: valid at the command, final rise driven before release
  chk_wr_valid: assert property (cmd == GDCT_WR
    |-> write_strobe_oe && !write_strobe_o)
    else $error("write strobe not driven at write");
  chk_wr_post: assert property ($rose(wdata_oe) |-> write_strobe_o
    ##1 !write_strobe_o ##1 write_strobe_o && write_strobe_oe ##1 !write_strobe_oe)
    else $error("write strobe postamble wrong");
  // Read strobes: preamble low, data edge, final rise by the memory
  // Memory sees the read in the command cycle, so preamble comes three edges on
  chk_rd_strobe: assert property (cmd == GDCT_RD |-> ##3
    read_strobe_oe == 4'hf && read_strobe_o == 4'h0 ##1 read_strobe_o == 4'hf && rdata_oe
    ##1 read_strobe_o == 4'h0 ##1 read_strobe_o == 4'hf && read_strobe_oe == 4'hf)
    else $error("read strobe sequence wrong");
endmodule

/* File: tb/gdct_test.sv */
// Bench: controller and memory joined by the link, driven over Avalon-MM.
// Assumes a 100 MHz clock; DLL countdown shortened to 20 cycles.
`timescale 1ns/100ps
module gdct_test;
  import gdct_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  avs_address = 3'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  gdct_cmd_t   issued_cmd;
  gdct_cnt_t   dll_wait;
  logic        dll_locked;
  logic        in_buf_en;
  logic [7:0]  bank_open;
  logic [2:0]  wl_cur;
  logic [31:0] q;
  int          failures = 0;
  int          total_checks = 0;
  gdct_link_if lnk ();

  // Free-running clock
  always #5 sys_clk = ~sys_clk;

  gdct_ctrl #(.DLL_CYCLES(20)) gdct_ctrl_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .issued_cmd(issued_cmd), .lnk(lnk.ctrl));
  gdct_mem #(.DLL_CYCLES(20)) gdct_mem_i (.sys_clk(sys_clk), .rst_n(rst_n), .lnk(lnk.mem),
    .dll_wait(dll_wait), .dll_locked(dll_locked), .in_buf_en(in_buf_en),
    .bank_open(bank_open), .wl_cur(wl_cur));
  gdct_link_checker gdct_link_checker_i (.sys_clk(sys_clk), .rst_n(rst_n), .cke(lnk.cke),
    .cmd(lnk.cmd), .mode(lnk.mode), .wdata_oe(lnk.wdata_oe),
    .write_strobe_o(lnk.write_strobe_o), .write_strobe_oe(lnk.write_strobe_oe),
    .rdata_oe(lnk.rdata_oe), .read_strobe_o(lnk.read_strobe_o),
    .read_strobe_oe(lnk.read_strobe_oe));

  // Verdict; the only place the run ends
  task automatic stop_test;
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One compare for every result, widened to 32 bits
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Transfer held until waitrequest is seen low at an edge; bounded wait
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 300);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 300)
    begin
      failures++;
      stop_test();
    end
  endtask

  // Poll one status bit until it reaches the wanted level
  task automatic wait_st(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, 3'h4, 32'h0);
      n++;
    end
    while (q[b] !== v && n < 100);
    cmp({31'h0, q[b]}, {31'h0, v});
  endtask

  // Command register write, no auto precharge
  task automatic cmd(input logic [2:0] op, input logic [2:0] b);
    bus(1'b1, 3'h0, {26'h0, b, op});
  endtask

  // Main sequence: reset, every write latency, DLL reset, refresh rate
  initial
  begin
    int n;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(1'b0, 3'h1, 32'h0);
    cmp(q, 32'h0000_0011);
    wait_st(1, 1'b1);
    for (int w = 1; w <= 6; w++)
    begin
      bus(1'b1, 3'h1, 32'(w));
      cmd(3'h1, 3'h0);
      cmd(3'h2, w[2:0]);
      bus(1'b1, 3'h2, 32'ha5c3_0f00 | 32'(w));
      cmd(3'h4, w[2:0]);
      cmd(3'h3, w[2:0]);
      wait_st(2, 1'b1);
      cmp({24'h0, bank_open}, 32'h1 << w);
      cmp({29'h0, issued_cmd}, 32'h0000_0003);
      bus(1'b0, 3'h3, 32'h0);
      cmp(q, 32'ha5c3_0f00 | 32'(w));
      cmp({29'h0, wl_cur}, 32'(w));
      cmp({31'h0, in_buf_en}, {31'h0, w == 1 || w == 3});
      cmd(3'h5, w[2:0]);
    end
    // Read with auto precharge must leave the row closed
    cmd(3'h2, 3'h0);
    bus(1'b1, 3'h0, 32'h0000_0043);
    wait_st(2, 1'b1);
    cmp({24'h0, bank_open}, 32'h0000_0000);
    cmd(3'h7, 3'h0);
    wait_st(1, 1'b0);
    cmp({31'h0, dll_locked}, 32'h0000_0000);
    wait_st(1, 1'b1);
    cmp({15'h0, dll_locked, dll_wait}, 32'h0001_0000);
    n = 0;
    repeat (780)
    begin
      @(posedge sys_clk);
      n += int'(lnk.cmd === GDCT_REF);
    end
    cmp(32'(n), 32'h2);
    stop_test();
  end
endmodule
